// ---- pkg/trace_capture_pkg.sv ----
/*
  constants, register map and types for the servo trace capture engine.
  assumes a 200 MHz core clock and an external shared sample table write port.
*/
package trace_capture_pkg;
    localparam int AXI_AW = 8;
    localparam int DATA_W = 32;
    localparam int TBL_AW = 16;
    localparam int PERIOD_W = 16;
    localparam int SRC_W = 3;
    localparam int NUM_SRC = 4;
    localparam int CNT_W = 18;

    localparam logic [AXI_AW-1:0] ADDR_CTRL   = 8'h00;
    localparam logic [AXI_AW-1:0] ADDR_PERIOD = 8'h04;
    localparam logic [AXI_AW-1:0] ADDR_START  = 8'h08;
    localparam logic [AXI_AW-1:0] ADDR_STOP   = 8'h0C;
    localparam logic [AXI_AW-1:0] ADDR_SRC    = 8'h10;
    localparam logic [AXI_AW-1:0] ADDR_POS    = 8'h14;
    localparam logic [AXI_AW-1:0] ADDR_SERVO  = 8'h18;
    localparam logic [AXI_AW-1:0] ADDR_STATUS = 8'h1C;

    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_TRIG_BIT = 1;
    localparam int SERVO_SEL_BIT = 0;
    localparam int STAT_ARMED_BIT = 0;
    localparam int STAT_RUN_BIT = 1;

    localparam logic [PERIOD_W-1:0] PERIOD_RST = 16'h0001;
    localparam logic [TBL_AW-1:0]   START_RST  = 16'h0000;
    localparam logic [TBL_AW-1:0]   STOP_RST   = 16'h0000;

    localparam logic [SRC_W-1:0] SRC_NONE      = 3'h0;
    localparam logic [SRC_W-1:0] SRC_MEAS_POS  = 3'h1;
    localparam logic [SRC_W-1:0] SRC_DEM_POS   = 3'h2;
    localparam logic [SRC_W-1:0] SRC_MEAS_VEL  = 3'h3;
    localparam logic [SRC_W-1:0] SRC_AUX       = 3'h4;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    localparam int CLK_FREQ_MHZ = 200;
    localparam int SERVO_SHORT_US = 500;
    localparam int SERVO_LONG_US = 1000;
    localparam int SERVO_SHORT_CYCLES = SERVO_SHORT_US * CLK_FREQ_MHZ;
    localparam int SERVO_LONG_CYCLES = SERVO_LONG_US * CLK_FREQ_MHZ;

    typedef enum logic [1:0] {ST_OFF, ST_ARMED, ST_RUN, ST_WRITE} state_t;
endpackage

// ---- rtl/servo_trace_capture.sv ----
/*
  servo trace capture engine with an AXI4-Lite register slave and a write port
  into the shared sample table.
  assumes the table arbiter accepts one write per cycle and that the motion
  inputs are synchronous to core_clk.
*/
// Register access over AXI4-Lite and the address map are this design's own decisions.
`timescale 1ns/1ps
module servo_trace_capture
    import trace_capture_pkg::*;
#(
    parameter int unsigned SERVO_SHORT_CYC = SERVO_SHORT_CYCLES,
    parameter int unsigned SERVO_LONG_CYC  = SERVO_LONG_CYCLES
)(
    input  wire logic              core_clk,
    input  wire logic              resetn,
    input  wire logic [AXI_AW-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [DATA_W-1:0] s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [AXI_AW-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [DATA_W-1:0]      s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire logic [DATA_W-1:0] encoderCount,
    input  wire logic [DATA_W-1:0] demandPosition,
    input  wire logic [DATA_W-1:0] auxValue,
    output logic                   servoTick,
    output logic                   tableWrEn,
    output logic [TBL_AW-1:0]      tableWrAddr,
    output logic [DATA_W-1:0]      tableWrData
);

    state_t                state_reg, state_next;
    logic                  awHeld_reg, awHeld_next;
    logic                  wHeld_reg, wHeld_next;
    logic [AXI_AW-1:0]     awAddr_reg, awAddr_next;
    logic [DATA_W-1:0]     wData_reg, wData_next;
    logic [3:0]            wStrb_reg, wStrb_next;
    logic                  bValid_reg, bValid_next;
    logic [1:0]            bResp_reg, bResp_next;
    logic                  rValid_reg, rValid_next;
    logic [1:0]            rResp_reg, rResp_next;
    logic [DATA_W-1:0]     rData_reg, rData_next;
    logic                  enable_reg, enable_next;
    logic [PERIOD_W-1:0]   period_reg, period_next;
    logic [TBL_AW-1:0]     start_reg, start_next;
    logic [TBL_AW-1:0]     stop_reg, stop_next;
    logic [NUM_SRC*SRC_W-1:0] srcSel_reg, srcSel_next;
    logic                  servoSel_reg, servoSel_next;
    logic [CNT_W-1:0]      tickCnt_reg, tickCnt_next;
    logic [DATA_W-1:0]     prevEnc_reg, prevEnc_next;
    logic [DATA_W-1:0]     measuredVelocity_reg, measuredVelocity_next;
    logic [PERIOD_W-1:0]   sampCnt_reg, sampCnt_next;
    logic [2:0]            numSrc_reg, numSrc_next;
    logic [TBL_AW-1:0]     secLen_reg, secLen_next;
    logic [TBL_AW-1:0]     pos_reg, pos_next;
    logic [TBL_AW-1:0]     secBase_reg, secBase_next;
    logic [1:0]            wrIdx_reg, wrIdx_next;
    logic [DATA_W-1:0]     snap_reg [NUM_SRC];
    logic [DATA_W-1:0]     snap_next [NUM_SRC];
    logic [DATA_W-1:0]     srcVal [NUM_SRC];
    logic                  tblWe_reg, tblWe_next;
    logic [TBL_AW-1:0]     tblAddr_reg, tblAddr_next;
    logic [DATA_W-1:0]     tblData_reg, tblData_next;

    logic                  doWrite;
    logic [DATA_W-1:0]     merged;
    logic                  armRise;
    logic                  trigPulse;
    logic [CNT_W-1:0]      tickLen;
    logic [TBL_AW:0]       span;
    logic [TBL_AW:0]       secDiv;
    logic [2:0]            leadCount;
    logic [DATA_W-1:0]     periodWord, startWord, stopWord, srcWord;

    function automatic logic [DATA_W-1:0] applyStrb(input logic [DATA_W-1:0] old,
                                                    input logic [DATA_W-1:0] nw,
                                                    input logic [3:0] strb);
        logic [DATA_W-1:0] res;
        res = old;
        for (int b = 0; b < 4; b++)
        begin
            if (strb[b])
            begin
                res[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        return res;
    endfunction

    // raw selection per source slot; no unit scaling on any path
    for (genvar k = 0; k < NUM_SRC; k++)
    begin : g_src
        always_comb
        begin
            case (srcSel_reg[k*SRC_W +: SRC_W])
                SRC_MEAS_POS: srcVal[k] = encoderCount;
                SRC_DEM_POS:  srcVal[k] = demandPosition;
                SRC_MEAS_VEL: srcVal[k] = measuredVelocity_reg;
                SRC_AUX:      srcVal[k] = auxValue;
                default:      srcVal[k] = '0;
            endcase
        end
    end

    // leading selected slots; slot zero always counts since software must fill it
    always_comb
    begin
        leadCount = 3'h1;
        if (srcSel_reg[1*SRC_W +: SRC_W] != SRC_NONE)
        begin
            leadCount = 3'h2;
            if (srcSel_reg[2*SRC_W +: SRC_W] != SRC_NONE)
            begin
                leadCount = 3'h3;
                if (srcSel_reg[3*SRC_W +: SRC_W] != SRC_NONE)
                begin
                    leadCount = 3'h4;
                end
            end
        end
    end

    assign span = {1'b0, stop_reg} - {1'b0, start_reg} + {{TBL_AW{1'b0}}, 1'b1};

    // equal sections; leftover words at the window end stay unused
    always_comb
    begin
        case (leadCount)
            3'h2:    secDiv = span >> 1;
            3'h3:    secDiv = span / 3'h3;
            3'h4:    secDiv = span >> 2;
            default: secDiv = span;
        endcase
    end

    assign tickLen = servoSel_reg ? SERVO_LONG_CYC[CNT_W-1:0] : SERVO_SHORT_CYC[CNT_W-1:0];
    // at-or-past so a shorter cycle never strands the counter
    assign servoTick = (tickCnt_reg >= tickLen - 1'b1);
    assign doWrite = awHeld_reg && wHeld_reg;
    assign merged = applyStrb({{(DATA_W-1){1'b0}}, enable_reg}, wData_reg, wStrb_reg);
    assign armRise = doWrite && (awAddr_reg == ADDR_CTRL) && merged[CTRL_EN_BIT] && !enable_reg;
    assign trigPulse = doWrite && (awAddr_reg == ADDR_CTRL) && merged[CTRL_TRIG_BIT];
    assign periodWord = applyStrb({{(DATA_W-PERIOD_W){1'b0}}, period_reg}, wData_reg, wStrb_reg);
    assign startWord = applyStrb({{(DATA_W-TBL_AW){1'b0}}, start_reg}, wData_reg, wStrb_reg);
    assign stopWord = applyStrb({{(DATA_W-TBL_AW){1'b0}}, stop_reg}, wData_reg, wStrb_reg);
    assign srcWord = applyStrb({{(DATA_W-NUM_SRC*SRC_W){1'b0}}, srcSel_reg}, wData_reg, wStrb_reg);

    assign s_axi_awready = !awHeld_reg && !bValid_reg;
    assign s_axi_wready  = !wHeld_reg && !bValid_reg;
    assign s_axi_arready = !rValid_reg;
    assign s_axi_bvalid  = bValid_reg;
    assign s_axi_bresp   = bResp_reg;
    assign s_axi_rvalid  = rValid_reg;
    assign s_axi_rresp   = rResp_reg;
    assign s_axi_rdata   = rData_reg;
    assign tableWrEn     = tblWe_reg;
    assign tableWrAddr   = tblAddr_reg;
    assign tableWrData   = tblData_reg;

    always_comb
    begin
        awHeld_next = awHeld_reg;
        wHeld_next = wHeld_reg;
        awAddr_next = awAddr_reg;
        wData_next = wData_reg;
        wStrb_next = wStrb_reg;
        bValid_next = bValid_reg;
        bResp_next = bResp_reg;
        rValid_next = rValid_reg;
        rResp_next = rResp_reg;
        rData_next = rData_reg;
        enable_next = enable_reg;
        period_next = period_reg;
        start_next = start_reg;
        stop_next = stop_reg;
        srcSel_next = srcSel_reg;
        servoSel_next = servoSel_reg;
        if (s_axi_awvalid && s_axi_awready)
        begin
            awHeld_next = 1'b1;
            awAddr_next = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            wHeld_next = 1'b1;
            wData_next = s_axi_wdata;
            wStrb_next = s_axi_wstrb;
        end
        if (bValid_reg && s_axi_bready)
        begin
            bValid_next = 1'b0;
        end
        if (doWrite)
        begin
            awHeld_next = 1'b0;
            wHeld_next = 1'b0;
            bValid_next = 1'b1;
            bResp_next = RESP_OKAY;
            if (awAddr_reg == ADDR_CTRL)
            begin
                enable_next = merged[CTRL_EN_BIT];
            end
            else if (awAddr_reg == ADDR_PERIOD)
            begin
                period_next = periodWord[PERIOD_W-1:0];
            end
            else if (awAddr_reg == ADDR_START)
            begin
                start_next = startWord[TBL_AW-1:0];
            end
            else if (awAddr_reg == ADDR_STOP)
            begin
                stop_next = stopWord[TBL_AW-1:0];
            end
            else if (awAddr_reg == ADDR_SRC)
            begin
                srcSel_next = srcWord[NUM_SRC*SRC_W-1:0];
            end
            else if (awAddr_reg == ADDR_SERVO)
            begin
                if (wStrb_reg[0])
                begin
                    servoSel_next = wData_reg[SERVO_SEL_BIT];
                end
            end
            else if (awAddr_reg == ADDR_POS || awAddr_reg == ADDR_STATUS)
            begin
                bResp_next = RESP_OKAY;
            end
            else
            begin
                bResp_next = RESP_SLVERR;
            end
        end
        if (rValid_reg && s_axi_rready)
        begin
            rValid_next = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready)
        begin
            rValid_next = 1'b1;
            rResp_next = RESP_OKAY;
            rData_next = '0;
            if (s_axi_araddr == ADDR_CTRL)
            begin
                rData_next[CTRL_EN_BIT] = enable_reg;
            end
            else if (s_axi_araddr == ADDR_PERIOD)
            begin
                rData_next[PERIOD_W-1:0] = period_reg;
            end
            else if (s_axi_araddr == ADDR_START)
            begin
                rData_next[TBL_AW-1:0] = start_reg;
            end
            else if (s_axi_araddr == ADDR_STOP)
            begin
                rData_next[TBL_AW-1:0] = stop_reg;
            end
            else if (s_axi_araddr == ADDR_SRC)
            begin
                rData_next[NUM_SRC*SRC_W-1:0] = srcSel_reg;
            end
            else if (s_axi_araddr == ADDR_POS)
            begin
                rData_next[TBL_AW-1:0] = start_reg + pos_reg;
            end
            else if (s_axi_araddr == ADDR_SERVO)
            begin
                rData_next[SERVO_SEL_BIT] = servoSel_reg;
            end
            else if (s_axi_araddr == ADDR_STATUS)
            begin
                rData_next[STAT_ARMED_BIT] = (state_reg == ST_ARMED);
                rData_next[STAT_RUN_BIT] = (state_reg == ST_RUN) || (state_reg == ST_WRITE);
            end
            else
            begin
                rResp_next = RESP_SLVERR;
            end
        end
    end

    always_comb
    begin
        state_next = state_reg;
        tickCnt_next = servoTick ? '0 : tickCnt_reg + 1'b1;
        prevEnc_next = prevEnc_reg;
        measuredVelocity_next = measuredVelocity_reg;
        sampCnt_next = sampCnt_reg;
        numSrc_next = numSrc_reg;
        secLen_next = secLen_reg;
        pos_next = pos_reg;
        secBase_next = secBase_reg;
        wrIdx_next = wrIdx_reg;
        snap_next = snap_reg;
        tblWe_next = 1'b0;
        tblAddr_next = tblAddr_reg;
        tblData_next = tblData_reg;
        if (servoTick)
        begin
            prevEnc_next = encoderCount;
            measuredVelocity_next = encoderCount - prevEnc_reg;
        end
        case (state_reg)
            ST_OFF:
            begin
                if (armRise)
                begin
                    state_next = ST_ARMED;
                    numSrc_next = leadCount;
                    secLen_next = (secDiv == '0) ? {{(TBL_AW-1){1'b0}}, 1'b1} : secDiv[TBL_AW-1:0];
                    pos_next = '0;
                end
            end
            ST_ARMED:
            begin
                if (trigPulse)
                begin
                    state_next = ST_WRITE;
                    snap_next = srcVal;
                    wrIdx_next = '0;
                    secBase_next = start_reg;
                end
            end
            ST_RUN:
            begin
                if (servoTick)
                begin
                    sampCnt_next = sampCnt_reg + 1'b1;
                    if (sampCnt_reg + 1'b1 >= period_reg)
                    begin
                        state_next = ST_WRITE;
                        snap_next = srcVal;
                        wrIdx_next = '0;
                        secBase_next = start_reg;
                    end
                end
            end
            ST_WRITE:
            begin
                tblWe_next = 1'b1;
                tblAddr_next = secBase_reg + pos_reg;
                tblData_next = snap_reg[wrIdx_reg];
                secBase_next = secBase_reg + secLen_reg;
                wrIdx_next = wrIdx_reg + 1'b1;
                if ({1'b0, wrIdx_reg} == numSrc_reg - 1'b1)
                begin
                    state_next = ST_RUN;
                    sampCnt_next = '0;
                    pos_next = (pos_reg + 1'b1 == secLen_reg) ? '0 : pos_reg + 1'b1;
                end
            end
            default:
            begin
                state_next = ST_OFF;
            end
        endcase
        // switching off wins over any sample in flight
        if (!enable_next)
        begin
            state_next = ST_OFF;
            tblWe_next = 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state_reg <= ST_OFF;
            awHeld_reg <= 1'b0;
            wHeld_reg <= 1'b0;
            awAddr_reg <= '0;
            wData_reg <= '0;
            wStrb_reg <= '0;
            bValid_reg <= 1'b0;
            bResp_reg <= RESP_OKAY;
            rValid_reg <= 1'b0;
            rResp_reg <= RESP_OKAY;
            rData_reg <= '0;
            enable_reg <= 1'b0;
            period_reg <= PERIOD_RST;
            start_reg <= START_RST;
            stop_reg <= STOP_RST;
            srcSel_reg <= '0;
            servoSel_reg <= 1'b0;
            tickCnt_reg <= '0;
            prevEnc_reg <= '0;
            measuredVelocity_reg <= '0;
            sampCnt_reg <= '0;
            numSrc_reg <= 3'h1;
            secLen_reg <= 16'h0001;
            pos_reg <= '0;
            secBase_reg <= '0;
            wrIdx_reg <= '0;
            snap_reg <= '{default: '0};
            tblWe_reg <= 1'b0;
            tblAddr_reg <= '0;
            tblData_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
            awHeld_reg <= awHeld_next;
            wHeld_reg <= wHeld_next;
            awAddr_reg <= awAddr_next;
            wData_reg <= wData_next;
            wStrb_reg <= wStrb_next;
            bValid_reg <= bValid_next;
            bResp_reg <= bResp_next;
            rValid_reg <= rValid_next;
            rResp_reg <= rResp_next;
            rData_reg <= rData_next;
            enable_reg <= enable_next;
            period_reg <= period_next;
            start_reg <= start_next;
            stop_reg <= stop_next;
            srcSel_reg <= srcSel_next;
            servoSel_reg <= servoSel_next;
            tickCnt_reg <= tickCnt_next;
            prevEnc_reg <= prevEnc_next;
            measuredVelocity_reg <= measuredVelocity_next;
            sampCnt_reg <= sampCnt_next;
            numSrc_reg <= numSrc_next;
            secLen_reg <= secLen_next;
            pos_reg <= pos_next;
            secBase_reg <= secBase_next;
            wrIdx_reg <= wrIdx_next;
            snap_reg <= snap_next;
            tblWe_reg <= tblWe_next;
            tblAddr_reg <= tblAddr_next;
            tblData_reg <= tblData_next;
        end
    end

endmodule // servo_trace_capture

// ---- dv/servo_trace_capture_chk.sv ----
/*
  concurrent checks on the trace capture engine ports.
  assumes the shortened servo lengths are handed on by the bind.
*/
`timescale 1ns/1ps
module servo_trace_capture_chk
    import trace_capture_pkg::*;
#(
    parameter int unsigned SERVO_SHORT_CYC = 20,
    parameter int unsigned SERVO_LONG_CYC  = 40
)(
    input wire logic              core_clk,
    input wire logic              resetn,
    input wire logic              s_axi_awready,
    input wire logic              s_axi_wready,
    input wire logic              s_axi_bvalid,
    input wire logic              s_axi_bready,
    input wire logic              s_axi_arready,
    input wire logic              s_axi_rvalid,
    input wire logic              s_axi_rready,
    input wire logic              servoTick,
    input wire logic              tableWrEn,
    input wire logic [TBL_AW-1:0] tableWrAddr
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);

    logic [17:0] tickGap;
    logic [3:0]  evtAge;

    // age saturates so a long idle run never wraps into a false cause
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            tickGap <= 18'h0;
            evtAge  <= 4'hF;
        end
        else
        begin
            tickGap <= servoTick ? 18'h0 : tickGap + 18'h1;
            evtAge  <= (servoTick || (s_axi_bvalid && s_axi_bready)) ? 4'h0 : (evtAge == 4'hF ? evtAge : evtAge + 4'h1);
        end
    end

    sequence s_burst4;
        tableWrEn [*4];
    endsequence
    sequence s_resp_done;
        s_axi_bvalid && s_axi_bready;
    endsequence

    property p_burst4;
        s_burst4 |=> !tableWrEn;
    endproperty
    a_burst4: assert property (p_burst4) else $error("more than four table words in a row");
    property p_wr_cause;
        $rose(tableWrEn) |-> evtAge <= 4'h4;
    endproperty
    a_wr_cause: assert property (p_wr_cause) else $error("table write without tick or trigger");
    property p_addr_up;
        tableWrEn && $past(tableWrEn) |-> tableWrAddr > $past(tableWrAddr);
    endproperty
    a_addr_up: assert property (p_addr_up) else $error("section addresses not ascending");
    property p_tick_pulse;
        servoTick |=> !servoTick [*7];
    endproperty
    a_tick_pulse: assert property (p_tick_pulse) else $error("servo tick too wide or too close");
    property p_tick_gap;
        tickGap <= SERVO_LONG_CYC;
    endproperty
    a_tick_gap: assert property (p_tick_gap) else $error("servo tick missing");
    property p_b_busy;
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
    endproperty
    a_b_busy: assert property (p_b_busy) else $error("write taken while response pending");
    property p_r_busy;
        s_axi_rvalid |-> !s_axi_arready;
    endproperty
    a_r_busy: assert property (p_r_busy) else $error("read taken while data pending");
    property p_b_once;
        s_resp_done |=> !s_axi_bvalid;
    endproperty
    a_b_once: assert property (p_b_once) else $error("write response repeated");
    property p_r_once;
        s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
    endproperty
    a_r_once: assert property (p_r_once) else $error("read data repeated");
endmodule // servo_trace_capture_chk

bind servo_trace_capture servo_trace_capture_chk #(
    .SERVO_SHORT_CYC(SERVO_SHORT_CYC),
    .SERVO_LONG_CYC (SERVO_LONG_CYC)
) u_servo_trace_capture_chk (
    .core_clk, .resetn, .s_axi_awready, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
    .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .servoTick, .tableWrEn, .tableWrAddr
);

// ---- dv/testbench.sv ----
/*
  self-checking bench for the trace capture engine.
  assumes servo lengths shortened to 20 and 40 cycles; bready and rready stay high.
*/
`timescale 1ns/1ps
module testbench
    import trace_capture_pkg::*;
();
    logic              core_clk = 1'h0;
    logic              resetn = 1'h0;
    logic [AXI_AW-1:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
    logic [DATA_W-1:0] s_axi_wdata = 32'h0, s_axi_rdata, tableWrData, encoderCount = 32'h0;
    logic [DATA_W-1:0] demandPosition = 32'h1234ABCD, auxValue = 32'h00C0FFEE;
    logic [3:0]        s_axi_wstrb = 4'hF;
    logic              s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_arvalid = 1'h0;
    logic              s_axi_bready = 1'h1, s_axi_rready = 1'h1;
    logic              s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic              servoTick, tableWrEn;
    logic [1:0]        s_axi_bresp, s_axi_rresp;
    logic [TBL_AW-1:0] tableWrAddr;
    logic [TBL_AW-1:0] qAddr[$];
    logic [DATA_W-1:0] qData[$];
    int                fails = 0, nChecks = 0, age = 0, gap = 0;

    always #2.5 core_clk = ~core_clk;

    servo_trace_capture #(.SERVO_SHORT_CYC(20), .SERVO_LONG_CYC(40)) u_servo_trace_capture (
        .core_clk, .resetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .encoderCount, .demandPosition, .auxValue, .servoTick, .tableWrEn, .tableWrAddr, .tableWrData
    );

    // encoder moves 5 edges per servo cycle so sample steps are predictable
    always @(posedge core_clk)
    begin
        if (servoTick === 1'h1)
            encoderCount <= encoderCount + 32'h5;
        if (servoTick === 1'h1)
            gap <= age;
        age <= (servoTick === 1'h1) ? 1 : age + 1;
        if (tableWrEn === 1'h1)
        begin
            qAddr.push_back(tableWrAddr);
            qData.push_back(tableWrData);
        end
    end

    task automatic print_verdict();
        if (fails == 0 && nChecks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] s);
        nChecks++;
        if (s !== e)
        begin
            fails++;
            $display("BAD %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic tmo(input bit hit);
        if (hit)
        begin
            fails++;
            $display("BAD wait expected done seen hang");
            print_verdict();
        end
    endtask

    task automatic wr(input logic [AXI_AW-1:0] a, input logic [DATA_W-1:0] d, input logic [1:0] er);
        int n;
        n = 0;
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid  <= 1'h1;
        do
        begin
            @(posedge core_clk);
            n++;
            if (s_axi_awready === 1'h1)
                s_axi_awvalid <= 1'h0;
            if (s_axi_wready === 1'h1)
                s_axi_wvalid <= 1'h0;
        end
        while (s_axi_bvalid !== 1'h1 && n < 50);
        tmo(n >= 50);
        chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
    endtask

    task automatic rd(input logic [AXI_AW-1:0] a, input logic [DATA_W-1:0] e, input logic [1:0] er, input string nm);
        int n;
        n = 0;
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'h1;
        do
        begin
            @(posedge core_clk);
            n++;
            if (s_axi_arready === 1'h1)
                s_axi_arvalid <= 1'h0;
        end
        while (s_axi_rvalid !== 1'h1 && n < 50);
        tmo(n >= 50);
        chk(nm, e, s_axi_rdata);
        chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
    endtask

    task automatic waitWords(input int k);
        int n;
        n = 0;
        while (qAddr.size() < k && n < 3000)
        begin
            @(posedge core_clk);
            n++;
        end
        tmo(n >= 3000);
    endtask

    task automatic t_regs();
        rd(ADDR_CTRL, 32'h0, RESP_OKAY, "ctrl");
        rd(ADDR_PERIOD, 32'h1, RESP_OKAY, "period");
        rd(ADDR_START, 32'h0, RESP_OKAY, "start");
        rd(ADDR_STATUS, 32'h0, RESP_OKAY, "status");
        rd(8'h20, 32'h0, RESP_SLVERR, "unmapped");
        wr(8'h24, 32'hFFFFFFFF, RESP_SLVERR);
        wr(ADDR_POS, 32'h0000FFFF, RESP_OKAY);
        rd(ADDR_POS, 32'h0, RESP_OKAY, "pos");
    endtask

    // four sources over twelve words: sections of three
    task automatic t_arm();
        wr(ADDR_PERIOD, 32'h2, RESP_OKAY);
        wr(ADDR_START, 32'h10, RESP_OKAY);
        wr(ADDR_STOP, 32'h1B, RESP_OKAY);
        wr(ADDR_SRC, 32'h8D1, RESP_OKAY);
        wr(ADDR_CTRL, 32'h1, RESP_OKAY);
        repeat (60) @(posedge core_clk);
        chk("armed words", 32'h0, 32'(qAddr.size()));
        rd(ADDR_STATUS, 32'h1, RESP_OKAY, "armed");
    endtask

    task automatic t_run();
        int k;
        wr(ADDR_CTRL, 32'h3, RESP_OKAY);
        waitWords(16);
        rd(ADDR_POS, 32'h11, RESP_OKAY, "pos run");
        rd(ADDR_STATUS, 32'h2, RESP_OKAY, "running");
        chk("tick gap", 32'h14, 32'(gap));
        for (int i = 0; i < 16; i++)
        begin
            k = i % 4;
            chk("addr", 32'(16'h10 + k * 3 + (i / 4) % 3), 32'(qAddr[i]));
            if (k == 1)
                chk("demand", demandPosition, qData[i]);
            if (k == 2)
                chk("velocity", 32'h5, qData[i]);
            if (k == 3)
                chk("aux", auxValue, qData[i]);
            if (k == 0 && i >= 8)
                chk("step", 32'hA, qData[i] - qData[i - 4]);
        end
    endtask

    // a gap in the source slots ends the list, so only one section
    task automatic t_stop();
        int n;
        wr(ADDR_CTRL, 32'h0, RESP_OKAY);
        n = qAddr.size();
        repeat (100) @(posedge core_clk);
        chk("stopped", 32'(n), 32'(qAddr.size()));
        wr(ADDR_SRC, 32'h44, RESP_OKAY);
        wr(ADDR_START, 32'h40, RESP_OKAY);
        wr(ADDR_STOP, 32'h42, RESP_OKAY);
        wr(ADDR_PERIOD, 32'h1, RESP_OKAY);
        wr(ADDR_SERVO, 32'h1, RESP_OKAY);
        qAddr.delete();
        qData.delete();
        wr(ADDR_CTRL, 32'h1, RESP_OKAY);
        wr(ADDR_CTRL, 32'h3, RESP_OKAY);
        waitWords(4);
        chk("tick gap long", 32'h28, 32'(gap));
        for (int i = 0; i < 4; i++)
        begin
            chk("addr one", 32'(16'h40 + i % 3), 32'(qAddr[i]));
            chk("aux one", auxValue, qData[i]);
        end
    endtask

    initial
    begin
        repeat (10) @(posedge core_clk);
        resetn <= 1'h1;
        @(posedge core_clk);
        t_regs();
        t_arm();
        t_run();
        t_stop();
        print_verdict();
    end
endmodule // testbench
